// ### include/sac_pkg.sv
/*
 * Package of the serial converter control block: field widths, reset
 * values, state encoding and the result word that leaves the block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sac_pkg;

	// ----------------------------------------------------------------
	// Field widths and positions
	// ----------------------------------------------------------------
	localparam int RES_BITS  = 12;
	localparam int CHAN_BITS = 3;
	localparam int CNT_BITS  = 4;
	localparam int SYNC_BITS = 4;

	localparam logic [CNT_BITS-1:0] CMD_LAST   = 4'h3;
	localparam logic [CNT_BITS-1:0] CONV_LAST  = 4'hB;
	localparam logic [CNT_BITS-1:0] LSB_LAST   = 4'hB;
	localparam logic [CNT_BITS-1:0] CNT_ZERO   = 4'h0;
	localparam logic [CNT_BITS-1:0] CNT_ONE    = 4'h1;

	// Synchroniser lanes
	localparam int LANE_SCLK = 0;
	localparam int LANE_CS_N = 1;
	localparam int LANE_DIN  = 2;
	localparam int LANE_COMP = 3;
	// Chip select lane starts low: a pin held low through reset gives no start
	localparam logic [SYNC_BITS-1:0] SYNC_INIT = 4'h0;

	// Command bit positions within the four captured bits
	localparam int CMD_MODE = 3;

	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [RES_BITS-1:0]  CODE_ZERO = 12'h000;
	localparam logic [RES_BITS-1:0]  CODE_MSB  = 12'h800;
	localparam logic [CHAN_BITS-1:0] CHAN_ZERO = 3'h0;
	localparam logic [CNT_BITS-1:0]  CMD_ZERO  = 4'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_WAIT_START,
		ST_CMD,
		ST_SAMPLE,
		ST_CONV,
		ST_LSB,
		ST_ZERO
	} sac_state_t;

	typedef struct packed {
		logic                 single_ended;
		logic [CHAN_BITS-1:0] chan;
		logic [RES_BITS-1:0]  code;
	} sac_word_t;

	localparam int WORD_BITS = $bits(sac_word_t);

endpackage

// ### hw/sac_sync.sv
/*
 * Two flip-flop synchroniser for a group of asynchronous levels.
 * Assumes one destination clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module sac_sync #(
	parameter int              W    = 4,
	parameter logic [W-1:0]    INIT = '0
) (
	// Clock and reset
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	// Levels
	input  wire logic [W-1:0]  async_i,
	output logic      [W-1:0]  sync_o
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta   <= INIT;
			sync_o <= INIT;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule

// ### hw/sac_buf2.sv
/*
 * Two-entry buffer with valid/ready on both sides; output comes from
 * registers. Assumes the drain may stall for any number of cycles.
 */
`timescale 1ns/1ps
module sac_buf2 #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	// Fill side
	input  wire logic          in_valid_i,
	output logic               in_ready_o,
	input  wire logic [W-1:0]  in_data_i,
	// Drain side
	output logic               out_valid_o,
	input  wire logic          out_ready_i,
	output logic      [W-1:0]  out_data_o
);

	logic         tail_v;
	logic [W-1:0] tail;
	logic         next_head_v;
	logic [W-1:0] next_head;
	logic         next_tail_v;
	logic [W-1:0] next_tail;
	logic         push;
	logic         pop;

	assign in_ready_o = !tail_v;

	always_comb begin
		push        = in_valid_i && !tail_v;
		pop         = out_valid_o && out_ready_i;
		next_head_v = out_valid_o;
		next_head   = out_data_o;
		next_tail_v = tail_v;
		next_tail   = tail;
		if (pop) begin
			if (tail_v) begin
				next_head   = tail;
				next_tail_v = 1'b0;
			end else begin
				next_head_v = push;
				next_head   = in_data_i;
			end
		end else if (push) begin
			if (!out_valid_o) begin
				next_head_v = 1'b1;
				next_head   = in_data_i;
			end else begin
				next_tail_v = 1'b1;
				next_tail   = in_data_i;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
			tail_v      <= 1'b0;
			tail        <= '0;
		end else begin
			out_valid_o <= next_head_v;
			out_data_o  <= next_head;
			tail_v      <= next_tail_v;
			tail        <= next_tail;
		end
	end

endmodule

// ### hw/sac_ctrl.sv
/*
 * Serial converter control: command capture, sample window, successive
 * approximation against an external comparator and serial result output.
 * Assumes the serial pins and the comparator are asynchronous to mclk_i
 * and that the serial clock is well below a quarter of mclk_i.
 * The comparator must settle within one serial clock; a word that
 * finds the buffer full waits in one pending register.
 */
// Functional notes
// - A transaction starts only on a falling edge of chip select.
// - Chip select high abandons any conversion and enters standby.
// - Serial clock edges pace command, sampling and every result bit.
// - Command bits are taken from the data input on rising clock edges.
// - The data output changes only on falling clock edges.
// - Sampling spans fourth rising edge after start to sixth falling edge.
// - After sampling a 12-bit result is produced, one bit per clock.
// - Each transaction's own command configures that conversion.
// - A channel pair is two single inputs or one pseudo-differential input.
// - Pseudo-differential: command picks which pair member is positive.
// - Pseudo-differential result saturates at 000h and FFFh.
// - Result is straight binary of 4096 times input over reference.
// - Start bit is first rising edge with select low and input high.
// - Low null bit on a falling edge, then 12 bits MSB first.
// - Further clocks resend the result LSB first, then zeros forever.
`timescale 1ns/1ps
module sac_ctrl #(
	parameter int RES_W  = sac_pkg::RES_BITS,
	parameter int CHAN_W = sac_pkg::CHAN_BITS
) (
	// Clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   rst_i,
	// Serial pins
	input  wire logic                   sclk_i,
	input  wire logic                   select_standby_n_i,
	input  wire logic                   din_i,
	output logic                        dout_o,
	output logic                        dout_oe_o,
	// Analog front end
	input  wire logic                   comp_i,
	output logic                        sample_o,
	output logic                        standby_o,
	output logic                        diff_mode_o,
	output logic         [CHAN_W-1:0]   chan_pos_o,
	output logic         [CHAN_W-1:0]   chan_neg_o,
	output logic         [RES_W-1:0]    dac_code_o,
	// Result stream
	input  wire logic                   res_ready_i,
	output logic                        res_valid_o,
	output sac_pkg::sac_word_t          res_data_o
);

	// ----------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------------------------------
	logic [sac_pkg::SYNC_BITS-1:0] pins;
	logic                          sclk_d;
	logic                          cs_n_d;
	logic                          rise;
	logic                          fall;
	logic                          cs_fall;
	logic                          cs_n;
	logic                          din;
	logic                          comp;

	sac_sync #(
		.W    (sac_pkg::SYNC_BITS),
		.INIT (sac_pkg::SYNC_INIT)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.async_i ({comp_i, din_i, select_standby_n_i, sclk_i}),
		.sync_o  (pins)
	);

	assign cs_n    = pins[sac_pkg::LANE_CS_N];
	assign din     = pins[sac_pkg::LANE_DIN];
	assign comp    = pins[sac_pkg::LANE_COMP];
	assign rise    = pins[sac_pkg::LANE_SCLK] && !sclk_d;
	assign fall    = !pins[sac_pkg::LANE_SCLK] && sclk_d;
	assign cs_fall = cs_n_d && !cs_n;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			// Serial clock idles low; chip select history starts low so a pin
			// held low through reset must go high and low again to start
			sclk_d <= 1'b0;
			cs_n_d <= 1'b0;
		end else begin
			sclk_d <= pins[sac_pkg::LANE_SCLK];
			cs_n_d <= cs_n;
		end
	end

	// ----------------------------------------------------------------
	// Result buffer
	// ----------------------------------------------------------------
	// A word that finds the buffer full waits in push_v and push_w
	logic               push_v;
	sac_pkg::sac_word_t push_w;
	logic               buf_ready;

	sac_buf2 #(
		.W (sac_pkg::WORD_BITS)
	) u_buf (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push_v),
		.in_ready_o  (buf_ready),
		.in_data_i   (push_w),
		.out_valid_o (res_valid_o),
		.out_ready_i (res_ready_i),
		.out_data_o  (res_data_o)
	);

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	sac_pkg::sac_state_t              state;
	logic [sac_pkg::CNT_BITS-1:0]     cnt;
	logic [sac_pkg::CNT_BITS-1:0]     cmd;
	logic [RES_W-1:0]                 mask;
	logic [RES_W-1:0]                 result;

	sac_pkg::sac_state_t              next_state;
	logic [sac_pkg::CNT_BITS-1:0]     next_cnt;
	logic [sac_pkg::CNT_BITS-1:0]     next_cmd;
	logic [RES_W-1:0]                 next_mask;
	logic [RES_W-1:0]                 next_result;
	logic [RES_W-1:0]                 next_dac;
	logic                             next_dout;
	logic                             next_oe;
	logic                             next_sample;
	logic                             next_diff;
	logic [CHAN_W-1:0]                next_pos;
	logic [CHAN_W-1:0]                next_neg;
	logic                             next_push_v;
	sac_pkg::sac_word_t               next_push_w;
	logic [RES_W-1:0]                 decided;
	logic                             next_standby;

	// ----------------------------------------------------------------
	// Next values
	// ----------------------------------------------------------------
	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		next_cmd    = cmd;
		next_mask   = mask;
		next_result = result;
		next_dac    = dac_code_o;
		next_dout   = dout_o;
		next_oe     = dout_oe_o;
		next_sample = sample_o;
		next_diff   = diff_mode_o;
		next_pos    = chan_pos_o;
		next_neg    = chan_neg_o;
		next_push_v = push_v && !buf_ready;
		next_push_w = push_w;
		decided     = comp ? dac_code_o : (dac_code_o & ~mask);
		// Deselect overrides every state; a queued word survives it
		if (cs_n) begin
			next_state  = sac_pkg::ST_STANDBY;
			next_oe     = 1'b0;
			next_dout   = 1'b0;
			next_sample = 1'b0;
		end else begin
			case (state)
				sac_pkg::ST_STANDBY: begin
					// Only a fresh fall of chip select opens a frame
					if (cs_fall) begin
						next_state = sac_pkg::ST_WAIT_START;
					end
				end
				sac_pkg::ST_WAIT_START: begin
					// Leading zeros on the data input are skipped
					if (rise && din) begin
						next_state = sac_pkg::ST_CMD;
						next_cnt   = sac_pkg::CNT_ZERO;
					end
				end
				sac_pkg::ST_CMD: begin
					if (rise) begin
						next_cmd = {cmd[sac_pkg::CNT_BITS-2:0], din};
						next_cnt = cnt + sac_pkg::CNT_ONE;
						if (cnt == sac_pkg::CMD_LAST) begin
							next_state  = sac_pkg::ST_SAMPLE;
							next_cnt    = sac_pkg::CNT_ZERO;
							next_sample = 1'b1;
							// Mode bit is in cmd[2] while the last channel bit is still on din
							next_diff   = !cmd[sac_pkg::CMD_MODE-1];
							if (cmd[sac_pkg::CMD_MODE-1]) begin
								next_pos = {cmd[1:0], din};
								next_neg = sac_pkg::CHAN_ZERO;
							end else begin
								next_pos = {cmd[1:0], din};
								next_neg = {cmd[1:0], !din};
							end
						end
					end
				end
				sac_pkg::ST_SAMPLE: begin
					// The spare rise arms the close; the next fall ends sampling
					if (rise) begin
						next_cnt = sac_pkg::CNT_ONE;
					end else if (fall && cnt == sac_pkg::CNT_ONE) begin
						next_sample = 1'b0;
						next_oe     = 1'b1;
						next_dout   = 1'b0;
						next_dac    = sac_pkg::CODE_MSB;
						next_mask   = sac_pkg::CODE_MSB;
						next_cnt    = sac_pkg::CNT_ZERO;
						next_state  = sac_pkg::ST_CONV;
					end
				end
				sac_pkg::ST_CONV: begin
					if (fall) begin
						// Comparator result fixes one bit per clock
						next_dout   = comp;
						next_result = decided;
						next_dac    = decided | (mask >> 1);
						next_mask   = mask >> 1;
						next_cnt    = cnt + sac_pkg::CNT_ONE;
						if (cnt == sac_pkg::CONV_LAST) begin
							// Last trial: keep only the decided bits and queue the word
							next_dac    = decided;
							next_state  = sac_pkg::ST_LSB;
							next_cnt    = sac_pkg::CNT_ONE;
							next_push_v = 1'b1;
							next_push_w = '{single_ended: !diff_mode_o, chan: chan_pos_o, code: decided};
						end
					end
				end
				sac_pkg::ST_LSB: begin
					// Bit 0 closed the MSB-first run, so the resend starts at bit 1
					if (fall) begin
						next_dout = result[cnt];
						next_cnt  = cnt + sac_pkg::CNT_ONE;
						if (cnt == sac_pkg::LSB_LAST) begin
							next_state = sac_pkg::ST_ZERO;
						end
					end
				end
				sac_pkg::ST_ZERO: begin
					// Zeros for as long as the host keeps clocking
					if (fall) begin
						next_dout = 1'b0;
					end
				end
				default: begin
					next_state = sac_pkg::ST_STANDBY;
				end
			endcase
		end
		next_standby = (next_state == sac_pkg::ST_STANDBY);
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state       <= sac_pkg::ST_STANDBY;
			cnt         <= sac_pkg::CNT_ZERO;
			cmd         <= sac_pkg::CMD_ZERO;
			mask        <= sac_pkg::CODE_ZERO;
			result      <= sac_pkg::CODE_ZERO;
			dac_code_o  <= sac_pkg::CODE_ZERO;
			dout_o      <= 1'b0;
			dout_oe_o   <= 1'b0;
			sample_o    <= 1'b0;
			standby_o   <= 1'b1;
			diff_mode_o <= 1'b0;
			chan_pos_o  <= sac_pkg::CHAN_ZERO;
			chan_neg_o  <= sac_pkg::CHAN_ZERO;
			push_v      <= 1'b0;
			push_w      <= '0;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			cmd         <= next_cmd;
			mask        <= next_mask;
			result      <= next_result;
			dac_code_o  <= next_dac;
			dout_o      <= next_dout;
			dout_oe_o   <= next_oe;
			sample_o    <= next_sample;
			standby_o   <= next_standby;
			diff_mode_o <= next_diff;
			chan_pos_o  <= next_pos;
			chan_neg_o  <= next_neg;
			push_v      <= next_push_v;
			push_w      <= next_push_w;
		end
	end

endmodule

// ### sim/sac_ctrl_sva.sv
/*
 * Checker of the serial converter control block, bound to sac_ctrl.
 * Assumes the bench serial clock of 160 ns against the 10 ns mclk_i.
 */
`timescale 1ns/1ps
module sac_ctrl_chk (
	// Clock and reset
	input wire logic		mclk_i,
	input wire logic		rst_i,
	// Serial pins
	input wire logic		sclk_i,
	input wire logic		select_standby_n_i,
	input wire logic		din_i,
	input wire logic		dout_o,
	input wire logic		dout_oe_o,
	// Analog side
	input wire logic		comp_i,
	input wire logic		sample_o,
	input wire logic		standby_o,
	input wire logic		diff_mode_o,
	input wire logic [2:0]	chan_pos_o,
	input wire logic [2:0]	chan_neg_o,
	input wire logic [11:0]	dac_code_o,
	// Result stream
	input wire logic		res_ready_i,
	input wire logic		res_valid_o,
	input wire sac_pkg::sac_word_t	res_data_o
);
	// ----
	// Sample window length counter
	// ----
	logic [7:0]	samp_cnt;
	logic [7:0]	next_samp_cnt;
	always_comb next_samp_cnt = sample_o ? samp_cnt + 8'h01 : 8'h00;
	always_ff @(posedge mclk_i) samp_cnt <= rst_i ? 8'h00 : next_samp_cnt;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	standby_quiet_a: assert property (standby_o |-> !dout_oe_o && !sample_o)
		else $error("output or sampling active in standby");
	cs_exit_a: assert property ($rose(select_standby_n_i) |-> ##[1:6] standby_o && !dout_oe_o)
		else $error("no standby after deselect");
	start_cs_a: assert property ($fell(standby_o) |-> !select_standby_n_i)
		else $error("left standby while deselected");
	dout_fall_a: assert property (dout_oe_o && $past(dout_oe_o) && $changed(dout_o)
		|-> !sclk_i && $past(sclk_i, 8))
		else $error("data out moved off a falling clock");
	null_first_a: assert property ($rose(dout_oe_o) |-> !dout_o && !sample_o && dac_code_o == 12'h800)
		else $error("bad null bit");
	// One and a half serial clocks of 16 mclk each, with synchroniser slack
	samp_len_a: assert property ($fell(sample_o) |-> samp_cnt >= 8'h16 && samp_cnt <= 8'h1A)
		else $error("sample window length wrong");
	cfg_hold_a: assert property (sample_o && $past(sample_o) |-> $stable({diff_mode_o, chan_pos_o, chan_neg_o}))
		else $error("configuration moved while sampling");
	pair_map_a: assert property (sample_o |->
		chan_neg_o == (diff_mode_o ? {chan_pos_o[2:1], ~chan_pos_o[0]} : 3'h0))
		else $error("negative channel wrong");
	sar_step_a: assert property ($changed(dac_code_o) && dout_oe_o |-> !sclk_i)
		else $error("trial code moved off a falling clock");
	res_hold_a: assert property (res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
		else $error("result dropped while stalled");
endmodule

bind sac_ctrl sac_ctrl_chk chk (.mclk_i, .rst_i, .sclk_i, .select_standby_n_i, .din_i, .dout_o, .dout_oe_o,
	.comp_i, .sample_o, .standby_o, .diff_mode_o, .chan_pos_o, .chan_neg_o, .dac_code_o,
	.res_ready_i, .res_valid_o, .res_data_o);

// ### sim/sac_host.sv
/*
 * Host serial master: leading zeros, start bit, command, result capture.
 * Assumes the bench clock; pins change on its falling edge.
 */
`timescale 1ns/1ps
module sac_host (
	// Bench clock
	input wire logic	mclk_i,
	// Device pins
	input wire logic	dout_i,
	input wire logic	dout_oe_i,
	output logic		sclk_o,
	output logic		sel_n_o,
	output logic		din_o
);
	initial begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		din_o = 1'b0;
	end
	task automatic half();
		repeat (8) @(negedge mclk_i);
	endtask
	// ----
	// One frame; rx keeps the last 28 bits read after the idle clock
	// ----
	task automatic frame(input logic [3:0] cmd, input int lead, input int nclk,
		output logic [27:0] rx, output logic pre_oe);
		logic [7:0] bits;
		bits = {1'b1, cmd, 3'h0};
		rx = '0;
		pre_oe = 1'b0;
		sel_n_o = 1'b0;
		half();
		for (int k = 1; k <= nclk; k++) begin
			if (k <= lead) din_o = 1'b0;
			else if (k <= lead + 5) din_o = bits[lead + 8 - k];
			else din_o = ~din_o;
			half();
			sclk_o = 1'b1;
			// A released pin reads as the inverse of its last value
			if (k > lead + 6) rx = {rx[26:0], dout_oe_i ? dout_i : ~dout_i};
			else pre_oe = pre_oe | dout_oe_i;
			half();
			sclk_o = 1'b0;
		end
		half();
		sel_n_o = 1'b1;
		din_o = ~din_o;
		half();
	endtask
endmodule

// ### sim/tb.sv
/*
 * Testbench of sac_ctrl: host model on the serial pins, ideal comparator,
 * result stream drained by hand. Assumes the 100 MHz bench clock.
 */
`timescale 1ns/1ps
module tb;
	logic	mclk, rst, sclk, sel_n, din, dout, dout_oe, sample, standby, diff_mode;
	logic	res_ready, res_valid, samp_d, cap_diff;
	logic [2:0]	chan_pos, chan_neg, cap_pos, cap_neg;
	logic [11:0]	dac_code, vin;
	sac_pkg::sac_word_t	res_data;
	int	bad_count = 0;
	int	compares = 0;
	int	n_samp = 0;
	wire logic	comp = (vin >= dac_code);

	sac_ctrl dut (.mclk_i(mclk), .rst_i(rst), .sclk_i(sclk), .select_standby_n_i(sel_n), .din_i(din),
		.dout_o(dout), .dout_oe_o(dout_oe), .comp_i(comp), .sample_o(sample), .standby_o(standby),
		.diff_mode_o(diff_mode), .chan_pos_o(chan_pos), .chan_neg_o(chan_neg), .dac_code_o(dac_code),
		.res_ready_i(res_ready), .res_valid_o(res_valid), .res_data_o(res_data));
	sac_host host (.mclk_i(mclk), .dout_i(dout), .dout_oe_i(dout_oe), .sclk_o(sclk), .sel_n_o(sel_n),
		.din_o(din));

	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		samp_d <= sample;
		if (sample === 1'b1 && samp_d !== 1'b1) n_samp <= n_samp + 1;
		if (sample === 1'b1) {cap_diff, cap_pos, cap_neg} <= {diff_mode, chan_pos, chan_neg};
	end

	// ----
	// Shared tasks
	// ----
	task automatic wrap_up();
		$display("Mismatches %0d, compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic pop_word(input sac_pkg::sac_word_t exp);
		int n;
		n = 0;
		while (res_valid !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		if (res_valid !== 1'b1) begin
			bad_count++;
			wrap_up();
		end else begin
			check(res_data, exp);
			res_ready = 1'b1;
			@(negedge mclk);
			res_ready = 1'b0;
		end
	endtask
	task automatic convert(input logic [3:0] cmd, input int lead, input logic [11:0] v);
		logic [27:0] rx;
		logic [27:0] exp;
		logic pre;
		vin = v;
		host.frame(cmd, lead, lead + 34, rx, pre);
		exp = {1'b0, v, 15'h0};
		for (int i = 1; i < 12; i++) exp[15 - i] = v[i];
		check(rx, exp);
		check(pre, 1'b0);
		check({cap_diff, cap_pos, cap_neg}, {~cmd[3], cmd[2:0], cmd[3] ? 3'h0 : {cmd[2:1], ~cmd[0]}});
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_single();
		logic [11:0] v;
		for (int c = 0; c < 8; c++) begin
			v = 12'(c * 499 + 5);
			convert({1'b1, 3'(c)}, c % 3, v);
			pop_word({1'b1, 3'(c), v});
		end
	endtask
	task automatic t_diff();
		logic [11:0] v;
		for (int c = 0; c < 8; c++) begin
			v = c[0] ? 12'hFFF : 12'h000;
			convert({1'b0, 3'(c)}, 1, v);
			pop_word({1'b0, 3'(c), v});
		end
	endtask
	task automatic t_abort();
		int n0;
		logic [27:0] rx;
		logic pre;
		n0 = n_samp;
		host.frame(4'hF, 12, 10, rx, pre);
		check(n_samp - n0, 0);
		vin = 12'h5A5;
		host.frame(4'hA, 0, 12, rx, pre);
		check({standby, dout_oe, res_valid}, 3'h4);
		check(n_samp - n0, 1);
		convert(4'hD, 2, 12'h3C3);
		pop_word({1'b1, 3'h5, 12'h3C3});
	endtask
	task automatic t_fill();
		convert(4'h9, 0, 12'h111);
		convert(4'hE, 3, 12'hEEE);
		convert(4'h3, 0, 12'h777);
		check(res_valid, 1'b1);
		pop_word({1'b1, 3'h1, 12'h111});
		pop_word({1'b1, 3'h6, 12'hEEE});
		pop_word({1'b0, 3'h3, 12'h777});
		@(negedge mclk);
		check(res_valid, 1'b0);
	endtask

	initial begin
		rst = 1'b1;
		res_ready = 1'b0;
		vin = 12'h000;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		check({standby, dout_oe, sample, res_valid, dac_code}, 16'h8000);
		repeat (3) @(negedge mclk);
		t_single();
		t_diff();
		t_abort();
		t_fill();
		wrap_up();
	end
endmodule
